// ### logic/wdt_map.vh
// Constants shared by the watchdog core and its tick divider.
// Assumes a single 100 MHz clock and a 32-bit AXI4-Lite register port.
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// Register byte offsets.
`define WDT_AW 8
`define OFS_CMD 8'h00
`define OFS_TMO 8'h04
`define OFS_DLY 8'h08
`define OFS_ACT 8'h0C
`define OFS_STAT 8'h10

// Command word: function group in bits 15:8, subfunction in bits 7:0.
`define CMD_GRP_HI 15
`define CMD_GRP_LO 8
`define CMD_SUB_HI 7
`define CMD_SUB_LO 0
`define FN_GROUP 8'hE0
`define SUB_INIT 8'h00
`define SUB_TRIG 8'h01
`define CMD_STRB 4'h3

// Expiry actions.
`define ACT_RESET 1'b0
`define ACT_NMI 1'b1

// Reset values.
`define CMD_RST 16'h0000
`define TMO_RST 16'h0000
`define DLY_RST 15'h0000
`define FCNT_RST 8'h00
`define CNT_RST 7'h00

// Field widths and limits.
`define TMO_W 16
`define DLY_W 15
`define TMO_OFF 16'h0000
`define DLY_NONE 15'h0000

// Time base: one software unit is 200 ms, one hardware tick is 500 ms.
`define UNIT_MS 200
`define TICK_MS 500
`define CLK_MHZ 100
`define WDT_TICK_CYCLES (`TICK_MS * 1000 * `CLK_MHZ)
`define DIV_W 26

// Rounding thresholds in 200 ms units, at the midpoints between durations.
`define THR_0S5 16'h0003
`define THR_1S 16'h0007
`define THR_2S 16'h000F
`define THR_4S 16'h001E
`define THR_8S 16'h003C
`define THR_16S 16'h0078

// Duration codes: code k lasts 2**k ticks of 500 ms.
`define CODE_MAX 3'h6
`define CODE_NONE 3'h7
`define SPAN_ONE 7'h01
`define CNT_ONE 7'h01
`define FCNT_ONE 8'h01
`define FCNT_MAX 8'hFF

// Status word bit positions.
`define ST_EN 0
`define ST_STATE 1
`define ST_ACT 3
`define ST_TCODE 4
`define ST_DCODE 7
`define ST_EXP 10
`define ST_FCNT 16

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### logic/tick_div.v
// Divider that turns the system clock into a one-cycle tick enable.
// Assumes restart and run are synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.vh"

module tick_div #(
  parameter CYCLES = `WDT_TICK_CYCLES
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Control
  input wire run,
  input wire restart,
  // Tick enable
  output wire tick
);

  localparam integer LAST_FULL = CYCLES - 1;
  localparam [`DIV_W-1:0] LAST = LAST_FULL[`DIV_W-1:0];
  localparam [`DIV_W-1:0] ONE = {{(`DIV_W-1){1'b0}}, 1'b1};
  localparam [`DIV_W-1:0] ZERO = {`DIV_W{1'b0}};

  reg [`DIV_W-1:0] div_ff;
  reg tick_ff;

  assign tick = tick_ff;

  // A restart realigns the phase so the first tick after it is a full period.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= ZERO;
      tick_ff <= 1'b0;
    end else if (restart || !run) begin
      div_ff <= ZERO;
      tick_ff <= 1'b0;
    end else if (div_ff == LAST) begin
      div_ff <= ZERO;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + ONE;
      tick_ff <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### logic/wdt_core.v
// Watchdog core with an AXI4-Lite register port and two expiry actions.
// Assumes one 100 MHz clock and an AXI4-Lite master that keeps the protocol.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.vh"

module wdt_core #(
  parameter TICK_CYCLES = `WDT_TICK_CYCLES
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // AXI4-Lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [`WDT_AW-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [`WDT_AW-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  // Expiry actions
  output wire sys_reset_req,
  output wire nmi_req
);

  localparam [1:0] ST_OFF = 2'b00;
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_DLY = 2'b10;
  localparam [1:0] ST_FIRED = 2'b11;

  // Maps a count of 200 ms units to the nearest duration code.
  function [2:0] round_code;
    input [`TMO_W-1:0] n;
    begin
      if (n <= `THR_0S5) begin
        round_code = 3'h0;
      end else if (n <= `THR_1S) begin
        round_code = 3'h1;
      end else if (n <= `THR_2S) begin
        round_code = 3'h2;
      end else if (n <= `THR_4S) begin
        round_code = 3'h3;
      end else if (n <= `THR_8S) begin
        round_code = 3'h4;
      end else if (n <= `THR_16S) begin
        round_code = 3'h5;
      end else begin
        round_code = `CODE_MAX;
      end
    end
  endfunction
  // Number of 500 ms ticks in a duration code.
  function [6:0] span;
    input [2:0] code;
    begin
      span = `SPAN_ONE << code;
    end
  endfunction
  // True for every offset the register map answers.
  function is_mapped;
    input [`WDT_AW-1:0] a;
    begin
      is_mapped = (a == `OFS_CMD) || (a == `OFS_TMO) || (a == `OFS_DLY) ||
                  (a == `OFS_ACT) || (a == `OFS_STAT);
    end
  endfunction
  // Byte-lane merge of a write into an existing word.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = din[i*8 +: 8];
        end
      end
    end
  endfunction
  // Bus state.
  reg awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  reg [1:0] bresp_ff, rresp_ff;
  reg [31:0] rdata_ff;
  reg aw_held_ff, w_held_ff;
  reg [`WDT_AW-1:0] waddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  // Settings and watchdog state.
  reg [15:0] cmd_ff;
  reg [`TMO_W-1:0] tmo_cfg_ff;
  reg [`DLY_W-1:0] dly_cfg_ff;
  reg act_cfg_ff;
  reg [2:0] tmo_code_ff, dly_code_ff;
  reg act_ff;
  reg [1:0] state_ff;
  reg [6:0] cnt_ff;
  reg expired_ff;
  reg [7:0] fcnt_ff;
  reg sys_reset_ff, nmi_ff;
  reg [1:0] nxt_state;
  reg [6:0] nxt_cnt;
  reg nxt_fire, raw_fire;
  reg [31:0] stat_word;
  reg [31:0] rd_word;
  wire tick;
  wire aw_fire = s_axi_awvalid & awready_ff;
  wire w_fire = s_axi_wvalid & wready_ff;
  wire ar_fire = s_axi_arvalid & arready_ff;
  wire wr_go = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire wr_ok = is_mapped(waddr_ff);
  wire [31:0] wr_cmd = merge({16'h0000, cmd_ff}, wdata_ff, wstrb_ff);
  wire [31:0] wr_tmo = merge({16'h0000, tmo_cfg_ff}, wdata_ff, wstrb_ff);
  wire [31:0] wr_dly = merge({17'h00000, dly_cfg_ff}, wdata_ff, wstrb_ff);
  wire [31:0] wr_act = merge({31'h00000000, act_cfg_ff}, wdata_ff, wstrb_ff);
  // A command only counts when both low bytes are written together.
  wire cmd_wr = wr_go && (waddr_ff == `OFS_CMD) && ((wstrb_ff & `CMD_STRB) == `CMD_STRB);
  wire grp_ok = wdata_ff[`CMD_GRP_HI:`CMD_GRP_LO] == `FN_GROUP;
  wire init_cmd = cmd_wr && grp_ok && (wdata_ff[`CMD_SUB_HI:`CMD_SUB_LO] == `SUB_INIT);
  wire trig_cmd = cmd_wr && grp_ok && (wdata_ff[`CMD_SUB_HI:`CMD_SUB_LO] == `SUB_TRIG);
  // Timeout and delay counts are 200 ms units rounded to the tick ladder.
  wire [2:0] new_tcode = round_code(tmo_cfg_ff);
  wire [2:0] new_dcode = (dly_cfg_ff == `DLY_NONE) ? `CODE_NONE :
                         round_code({1'b0, dly_cfg_ff});
  wire run = (state_ff == ST_RUN) || (state_ff == ST_DLY);
  wire tmo_hit = tick && ((cnt_ff + `CNT_ONE) == span(tmo_code_ff));
  wire dly_hit = tick && ((cnt_ff + `CNT_ONE) == span(dly_code_ff));
  wire restart = init_cmd || trig_cmd || (nxt_state != state_ff) || nxt_fire;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign sys_reset_req = sys_reset_ff;
  assign nmi_req = nmi_ff;
  tick_div #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(run),
    .restart(restart),
    .tick(tick)
  );
  // Watchdog sequencing.
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_fire = 1'b0;
    case (state_ff)
      ST_RUN: begin
        if (trig_cmd) begin
          nxt_cnt = `CNT_RST;
        end else if (tmo_hit) begin
          nxt_cnt = `CNT_RST;
          if (dly_code_ff == `CODE_NONE) begin
            nxt_fire = 1'b1;
          end else begin
            nxt_state = ST_DLY;
          end
        end else if (tick) begin
          nxt_cnt = cnt_ff + `CNT_ONE;
        end
      end
      ST_DLY: begin
        if (trig_cmd) begin
          nxt_state = ST_RUN;
          nxt_cnt = `CNT_RST;
        end else if (dly_hit) begin
          nxt_cnt = `CNT_RST;
          nxt_fire = 1'b1;
        end else if (tick) begin
          nxt_cnt = cnt_ff + `CNT_ONE;
        end
      end
      ST_OFF, ST_FIRED: begin
        nxt_cnt = `CNT_RST;
      end
      default: begin
        nxt_state = ST_OFF;
        nxt_cnt = `CNT_RST;
      end
    endcase
    // A reset action parks the core; an interrupt action keeps it watching.
    if (nxt_fire) begin
      nxt_state = (act_ff == `ACT_RESET) ? ST_FIRED : ST_RUN;
    end
    // An init in the expiry cycle cancels the action but not the expiry record.
    raw_fire = nxt_fire;
    if (init_cmd) begin
      nxt_fire = 1'b0;
      nxt_cnt = `CNT_RST;
      nxt_state = (tmo_cfg_ff == `TMO_OFF) ? ST_OFF : ST_RUN;
    end
  end
  // Status word.
  always @* begin
    stat_word = 32'h00000000;
    stat_word[`ST_EN] = run;
    stat_word[`ST_STATE+1:`ST_STATE] = state_ff;
    stat_word[`ST_ACT] = act_ff;
    stat_word[`ST_TCODE+2:`ST_TCODE] = tmo_code_ff;
    stat_word[`ST_DCODE+2:`ST_DCODE] = dly_code_ff;
    stat_word[`ST_EXP] = expired_ff;
    stat_word[`ST_FCNT+7:`ST_FCNT] = fcnt_ff;
  end

  // Read mux; unmapped offsets read as zero.
  always @* begin
    case (s_axi_araddr)
      `OFS_CMD: rd_word = {16'h0000, cmd_ff};
      `OFS_TMO: rd_word = {16'h0000, tmo_cfg_ff};
      `OFS_DLY: rd_word = {17'h00000, dly_cfg_ff};
      `OFS_ACT: rd_word = {31'h00000000, act_cfg_ff};
      `OFS_STAT: rd_word = stat_word;
      default: rd_word = 32'h00000000;
    endcase
  end

  // AXI4-Lite write channel: address and data are taken in either order.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      waddr_ff <= `OFS_CMD;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_held_ff <= 1'b1;
        waddr_ff <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_ff <= 1'b0;
      end
      if (w_fire) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_ff <= 1'b0;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      // Ready drops once an item is held, so one write is in flight at a time.
      awready_ff <= ~(aw_fire | aw_held_ff) | wr_go ? ~(wr_go | bvalid_ff) & ~aw_fire : 1'b0;
      wready_ff <= ~(w_fire | w_held_ff) | wr_go ? ~(wr_go | bvalid_ff) & ~w_fire : 1'b0;
    end
  end

  // AXI4-Lite read channel.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `RESP_OKAY;
    end else begin
      if (ar_fire) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_word;
        rresp_ff <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        arready_ff <= 1'b0;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end else begin
        arready_ff <= ~rvalid_ff;
      end
    end
  end

  // Settings registers.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_ff <= `CMD_RST;
      tmo_cfg_ff <= `TMO_RST;
      dly_cfg_ff <= `DLY_RST;
      act_cfg_ff <= `ACT_RESET;
    end else if (wr_go) begin
      case (waddr_ff)
        `OFS_CMD: cmd_ff <= wr_cmd[15:0];
        `OFS_TMO: tmo_cfg_ff <= wr_tmo[`TMO_W-1:0];
        `OFS_DLY: dly_cfg_ff <= wr_dly[`DLY_W-1:0];
        `OFS_ACT: act_cfg_ff <= wr_act[0];
        default: cmd_ff <= cmd_ff;
      endcase
    end
  end

  // Watchdog state, applied settings and action outputs.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_OFF;
      cnt_ff <= `CNT_RST;
      tmo_code_ff <= 3'h0;
      dly_code_ff <= `CODE_NONE;
      act_ff <= `ACT_RESET;
      expired_ff <= 1'b0;
      fcnt_ff <= `FCNT_RST;
      sys_reset_ff <= 1'b0;
      nmi_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      // Settings change only on init; a retrigger leaves them alone.
      if (init_cmd) begin
        tmo_code_ff <= new_tcode;
        dly_code_ff <= new_dcode;
        act_ff <= act_cfg_ff;
      end
      // The expiry flag is set on a fire even if an init clears it then.
      if (raw_fire) begin
        expired_ff <= 1'b1;
      end else if (init_cmd) begin
        expired_ff <= 1'b0;
      end
      if (nxt_fire && (fcnt_ff != `FCNT_MAX)) begin
        fcnt_ff <= fcnt_ff + `FCNT_ONE;
      end
      // The reset request holds until system reset; a new init also drops it.
      sys_reset_ff <= (nxt_state == ST_FIRED);
      nmi_ff <= nxt_fire && (act_ff == `ACT_NMI);
    end
  end

endmodule
`default_nettype wire

// ### tb/wdt_core_monitor.sv
// Checker for the watchdog core's bus handshakes and expiry outputs.
// Assumes it is bound to wdt_core and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module wdt_core_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Expiry actions
  input wire logic sys_reset_req,
  input wire logic nmi_req
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence write_answer;
    (!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid;
  endsequence
  // A pending reset request may only drop through an init, which needs a recent write.
  sequence bus_quiet;
    !s_axi_awvalid && !$past(s_axi_awvalid);
  endsequence
  AST_WRITE_ANSWER: assert property (write_taken |=> write_answer)
    else $error("write response not given two cycles after the handshake");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was accepted");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not given one cycle after the address");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was accepted");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while read data pending");
  AST_NMI_PULSE: assert property (nmi_req |=> !nmi_req)
    else $error("interrupt request longer than one cycle");
  AST_RESET_HOLD: assert property (sys_reset_req and bus_quiet |=> sys_reset_req)
    else $error("reset request dropped without an init");
  AST_ONE_ACTION: assert property (!(sys_reset_req && nmi_req))
    else $error("both expiry actions at once");
  AST_QUIET_START: assert property ($rose(rstn) |-> (!sys_reset_req && !nmi_req) [*8])
    else $error("expiry action right after reset");
endmodule
bind wdt_core wdt_core_monitor wdt_core_monitor_i (.*);
`default_nettype wire

// ### tb/host_sw.sv
// Software model that reaches the watchdog registers as a bus master.
// Assumes the bench calls wr and rd one at a time after reset is released.
`timescale 1ns/10ps
`default_nettype none
module host_sw (
  // Clock
  input wire logic sys_clk,
  // Write channels
  output var logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output var logic [7:0] s_axi_awaddr,
  output var logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output var logic [31:0] s_axi_wdata,
  output var logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  output var logic s_axi_bready,
  // Read channels
  output var logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output var logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  output var logic s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
  end
  // Released payloads are inverted so a stale value is never mistaken for a live one.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (!s_axi_bvalid);
    // Ready comes late on purpose, so the slave must hold its answer for a cycle.
    s_axi_bready <= 1'b1;
    @(posedge sys_clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do @(posedge sys_clk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/watchdog_timeout_action_bench.sv
// Self-checking bench for the watchdog core with a short tick.
// Assumes host_sw drives the bus and the checker is bound to the core.
`timescale 1ns/10ps
`default_nettype none
module watchdog_timeout_action_bench;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sys_reset_req, nmi_req;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  int bad_count = 0;
  int checks_done = 0;
  int n;
  int tn[14] = '{1, 3, 4, 7, 8, 15, 16, 30, 31, 60, 61, 120, 121, 65535};
  logic [33:0] exp_q[$];
  logic [33:0] msk_q[$];
  logic [1:0] b_q[$];
  localparam logic [33:0] FULL = 34'h3FFFFFFFF;
  // A short tick keeps every timeout within a few hundred cycles.
  wdt_core #(.TICK_CYCLES(10)) wdt_core_i (.*);
  host_sw host_sw_i (.*);
  always #5 sys_clk = ~sys_clk;
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  always @(posedge sys_clk) begin
    if (rstn && s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      check("read", {s_axi_rresp, s_axi_rdata} & msk_q[0], exp_q[0]);
      exp_q.pop_front();
      msk_q.pop_front();
    end
  end
  always @(posedge sys_clk) begin
    if (rstn && s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      check("bresp", 34'(s_axi_bresp), 34'(b_q[0]));
      b_q.pop_front();
    end
  end
  task automatic rd_exp(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    host_sw_i.rd(a);
  endtask
  task automatic wr_exp(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    b_q.push_back(e);
    host_sw_i.wr(a, d);
  endtask
  // Random upper bits must not disturb the command decode.
  task automatic cmd(input logic [7:0] sub);
    wr_exp(8'h00, {16'($urandom), 8'hE0, sub}, 2'h0);
  endtask
  task automatic setup(input int t, input int d, input int act);
    wr_exp(8'h04, 32'(t), 2'h0);
    wr_exp(8'h08, 32'(d), 2'h0);
    wr_exp(8'h0C, 32'(act), 2'h0);
    cmd(8'h00);
  endtask
  task automatic waitc(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    n = $urandom(65806);
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd_exp(8'h10, 34'h380, FULL);
    rd_exp(8'h14, 34'h200000000, FULL);
    wr_exp(8'h18, 32'hFFFFFFFF, 2'h2);
    wr_exp(8'h10, 32'hFFFFFFFF, 2'h0);
    rd_exp(8'h10, 34'h380, FULL);
    setup(0, 0, 0);
    waitc(100);
    check("reset_req", 34'(sys_reset_req), 34'h0);
    rd_exp(8'h10, 34'h0, 34'h300000007);
    for (int i = 0; i < 14; i++) begin
      setup(tn[i], tn[i], 1);
      rd_exp(8'h10, 34'((i / 2) * 144 + 8), 34'h3000003F8);
    end
    setup(1, 0, 1);
    n = 0;
    repeat (35) begin
      waitc(1);
      n += int'(nmi_req);
    end
    check("nmi_count", 34'(n), 34'd3);
    setup(1, 5, 0);
    waitc(27);
    check("reset_req", 34'(sys_reset_req), 34'h0);
    waitc(6);
    check("reset_req", 34'(sys_reset_req), 34'h1);
    rd_exp(8'h10, 34'h6, 34'h6);
    setup(8, 0, 0);
    waitc(1);
    check("reset_req", 34'(sys_reset_req), 34'h0);
    repeat (6) begin
      waitc($urandom_range(20, 5));
      cmd(8'h01);
    end
    check("reset_req", 34'(sys_reset_req), 34'h0);
    rd_exp(8'h10, 34'h20, 34'h70);
    waitc(50);
    check("reset_req", 34'(sys_reset_req), 34'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire
